// File: design/adc_port_pkg.sv
// shared widths, sample struct and timing constants for the converter output port
// assumes a 40 MHz system clock; the conversion clock arrives as a pin and is sampled
package adc_port_pkg;
	localparam int          RESULT_WIDTH    = 8;
	localparam int          SAMPLE_WIDTH    = 10;
	localparam logic [7:0]  CODE_ZERO       = 8'h00;
	localparam logic [7:0]  CODE_FULL       = 8'hff;
	localparam logic [9:0]  LEVEL_RESET     = 10'h000;
	localparam logic [7:0]  RESULT_RESET    = 8'h00;
	localparam int          CLOCK_PERIOD_NS = 25;
	// output data settle time after a wake, in nanoseconds
	localparam int          WAKE_SETTLE_NS  = 1000;
	localparam int          WAKE_CYCLES     = WAKE_SETTLE_NS / CLOCK_PERIOD_NS;
	localparam logic [15:0] WAKE_COUNT      = 16'(WAKE_CYCLES);
	// number of pipeline stages on each clock phase giving 2.5 cycles of latency
	localparam int          FALL_STAGES     = 3;
	localparam int          RISE_STAGES     = 2;

	typedef struct packed {
		logic [9:0] level;
		logic [9:0] bottom;
		logic [9:0] top;
	} sample_s;
endpackage

// File: design/pipelined_adc_output_port.sv
// digital behaviour of an 8-bit pipelined sampling converter's output port
// assumes the conversion clock pin is much slower than clock and passes a
// two-stage synchroniser; analog values arrive as already digitised levels
`timescale 1ns/1ps

module pipelined_adc_output_port #(
	parameter int RESULT_WIDTH = adc_port_pkg::RESULT_WIDTH,
	parameter int SAMPLE_WIDTH = adc_port_pkg::SAMPLE_WIDTH
) (
	// system
	input  wire logic                          clock,
	input  wire logic                          srst,
	// conversion clock and control pins
	input  wire logic                          conversion_clock,
	input  wire logic                          low_power_request,
	// analog input and references as digitised levels
	input  wire adc_port_pkg::sample_s         sample_in,
	// result bus
	output logic      [RESULT_WIDTH-1:0]       result_out,
	output logic                               result_update,
	output logic                               output_settling
);

	initial begin
		if (RESULT_WIDTH != adc_port_pkg::RESULT_WIDTH || SAMPLE_WIDTH != adc_port_pkg::SAMPLE_WIDTH)
			$error("pipelined_adc_output_port: widths fixed by the package");
	end

	// synchronisers: first stage read only by second stage
	logic [1:0] cclk_sync_reg, cclk_sync_next;
	logic [1:0] lp_sync_reg, lp_sync_next;
	logic       cclk_prev_reg, cclk_prev_next;
	adc_port_pkg::sample_s s1_reg, s1_next, s2_reg, s2_next;

	always_comb begin
		cclk_sync_next = {cclk_sync_reg[0], conversion_clock};
		lp_sync_next   = {lp_sync_reg[0], low_power_request};
		cclk_prev_next = cclk_sync_reg[1];
		s1_next        = sample_in;
		s2_next        = s1_reg;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cclk_sync_reg <= 2'h0;
			lp_sync_reg   <= 2'h0;
			cclk_prev_reg <= 1'b0;
			s1_reg        <= '0;
			s2_reg        <= '0;
		end else begin
			cclk_sync_reg <= cclk_sync_next;
			lp_sync_reg   <= lp_sync_next;
			cclk_prev_reg <= cclk_prev_next;
			s1_reg        <= s1_next;
			s2_reg        <= s2_next;
		end
	end

	// edge detection waits until both sync stages and the previous-level flop
	// hold real pin samples; the pin often idles high, and reset values of zero
	// would otherwise look like a rising edge and fire a spurious update
	logic [1:0] prime_reg, prime_next;
	logic       primed;

	always_comb begin
		prime_next = prime_reg;
		if (prime_reg != 2'h3) begin
			prime_next = prime_reg + 2'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			prime_reg <= 2'h0;
		end else begin
			prime_reg <= prime_next;
		end
	end

	// three clocks after reset the previous-level flop holds a real pin sample
	assign primed = (prime_reg == 2'h3);

	logic cclk_s;
	logic low_power;
	logic fall_edge;
	logic rise_edge;
	assign cclk_s    = cclk_sync_reg[1];
	assign low_power = lp_sync_reg[1];
	// a halted conversion clock gives no edges, so every stage simply holds
	// edges are only one clock wide, so the conversion clock must keep each
	// phase at least one system clock long or edges are lost
	assign fall_edge = primed & cclk_prev_reg & ~cclk_s;
	assign rise_edge = primed & ~cclk_prev_reg & cclk_s;
	logic active;
	assign active    = ~low_power;

	// quantise a level to a saturating straight binary code
	function automatic logic [7:0] quantise(input adc_port_pkg::sample_s s);
		logic [9:0] span;
		logic [9:0] offs;
		logic [17:0] scaled;
		span   = 10'h000;
		offs   = 10'h000;
		scaled = 18'h00000;
		if (s.level <= s.bottom || s.top <= s.bottom) begin
			quantise = adc_port_pkg::CODE_ZERO;
		end else if (s.level >= s.top) begin
			quantise = adc_port_pkg::CODE_FULL;
		end else begin
			span     = s.top - s.bottom;
			offs     = s.level - s.bottom;
			scaled   = ({8'h00, offs} << 8) / {8'h00, span};
			quantise = scaled[7:0];
		end
	endfunction

	// pipeline: captured word on a fall, then fall/rise alternation to the output.
	// fall stage 0 captures, rise stage 0, fall stage 1, rise stage 1, fall 2,
	// output register on the next rise gives 2.5 cycles from capture
	logic [7:0] fall_pipe_reg [adc_port_pkg::FALL_STAGES];
	logic [7:0] fall_pipe_next[adc_port_pkg::FALL_STAGES];
	logic [7:0] rise_pipe_reg [adc_port_pkg::RISE_STAGES];
	logic [7:0] rise_pipe_next[adc_port_pkg::RISE_STAGES];
	logic [7:0] result_reg, result_next;
	logic       update_reg, update_next;

	always_comb begin
		fall_pipe_next = fall_pipe_reg;
		rise_pipe_next = rise_pipe_reg;
		result_next    = result_reg;
		update_next    = 1'b0;
		if (active && fall_edge) begin
			fall_pipe_next[0] = quantise(s2_reg);
			for (int i = 1; i < adc_port_pkg::FALL_STAGES; i++) begin
				fall_pipe_next[i] = rise_pipe_reg[i-1];
			end
		end
		if (active && rise_edge) begin
			for (int i = 0; i < adc_port_pkg::RISE_STAGES; i++) begin
				rise_pipe_next[i] = fall_pipe_reg[i];
			end
			// a new word every cycle, launched only from a rising edge
			result_next = fall_pipe_reg[adc_port_pkg::FALL_STAGES-1];
			update_next = 1'b1;
		end
		// low power freezes every stage, so the bus keeps the last result;
		// the frozen words come out first after a wake, which is why the
		// settle indicator stays up for a while after low power ends
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < adc_port_pkg::FALL_STAGES; i++) begin
				fall_pipe_reg[i] <= adc_port_pkg::RESULT_RESET;
			end
			for (int i = 0; i < adc_port_pkg::RISE_STAGES; i++) begin
				rise_pipe_reg[i] <= adc_port_pkg::RESULT_RESET;
			end
			result_reg <= adc_port_pkg::RESULT_RESET;
			update_reg <= 1'b0;
		end else begin
			fall_pipe_reg <= fall_pipe_next;
			rise_pipe_reg <= rise_pipe_next;
			result_reg    <= result_next;
			update_reg    <= update_next;
		end
	end

	// settle indicator: data is not trustworthy for a while after waking
	logic [15:0] settle_reg, settle_next;
	logic        lp_prev_reg, lp_prev_next;

	always_comb begin
		lp_prev_next = low_power;
		settle_next  = settle_reg;
		if (low_power) begin
			settle_next = adc_port_pkg::WAKE_COUNT;
		end else if (lp_prev_reg) begin
			settle_next = adc_port_pkg::WAKE_COUNT;
		end else if (settle_reg != 16'h0000) begin
			settle_next = settle_reg - 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			settle_reg  <= adc_port_pkg::WAKE_COUNT;
			lp_prev_reg <= 1'b0;
		end else begin
			settle_reg  <= settle_next;
			lp_prev_reg <= lp_prev_next;
		end
	end

	assign result_out      = result_reg;
	assign result_update   = update_reg;
	assign output_settling = (settle_reg != 16'h0000);

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	bus_on_rise_a: assert property ($changed(result_reg) |-> $past(rise_edge) && $past(active))
		else $error("result changed without a rising edge");
	update_rise_a: assert property (active && rise_edge |=> result_update)
		else $error("no update on rising edge");
	hold_low_power_a: assert property (low_power |=> $stable(result_reg))
		else $error("result moved in low power");
	hold_halt_a: assert property (!rise_edge |=> $stable(result_reg))
		else $error("result moved with no clock edge");
	capture_fall_a: assert property (active && fall_edge |=> fall_pipe_reg[0] == quantise($past(s2_reg)))
		else $error("capture missed on falling edge");
	low_zero_a: assert property (active && fall_edge && s2_reg.level <= s2_reg.bottom
		|=> fall_pipe_reg[0] == adc_port_pkg::CODE_ZERO)
		else $error("below bottom not zero");
	high_full_a: assert property (active && fall_edge && s2_reg.level >= s2_reg.top
		&& s2_reg.top > s2_reg.bottom |=> fall_pipe_reg[0] == adc_port_pkg::CODE_FULL)
		else $error("above top not full");
	launch_path_a: assert property (active && rise_edge
		|=> result_reg == $past(fall_pipe_reg[adc_port_pkg::FALL_STAGES-1]))
		else $error("wrong word launched");
	wake_settle_a: assert property ($fell(low_power) |=> output_settling)
		else $error("no settling after wake");
	active_conv_a: assert property (!low_power && rise_edge |=> result_update)
		else $error("not converting with request low");
	update_pulse_a: assert property (result_update |=> !result_update)
		else $error("update pulse longer than one cycle");
	update_rise_a2: assert property (result_update |-> $past(rise_edge))
		else $error("update without a rising edge");
	sleep_quiet_a: assert property (low_power |=> !result_update)
		else $error("update pulse in low power");
	sleep_capture_a: assert property (low_power |=> $stable(fall_pipe_reg[0]))
		else $error("capture stage moved in low power");
	sleep_rise_a: assert property (low_power |=> $stable(rise_pipe_reg[0]))
		else $error("rise stage moved in low power");
	halt_stage_a: assert property (!fall_edge && !rise_edge |=> $stable(fall_pipe_reg[0]))
		else $error("capture stage moved with no clock edge");
	stage_rise_a: assert property (active && rise_edge
		|=> rise_pipe_reg[0] == $past(fall_pipe_reg[0]))
		else $error("rise stage did not take the capture");
	stage_fall_a: assert property (active && fall_edge
		|=> fall_pipe_reg[adc_port_pkg::FALL_STAGES-1]
		== $past(rise_pipe_reg[adc_port_pkg::RISE_STAGES-1]))
		else $error("last fall stage did not take the rise stage");
	settle_bound_a: assert property (settle_reg <= adc_port_pkg::WAKE_COUNT)
		else $error("settle count above its limit");
	settle_reload_a: assert property (low_power |=> settle_reg == adc_port_pkg::WAKE_COUNT)
		else $error("settle count not reloaded in low power");
	settle_count_a: assert property (!low_power && !lp_prev_reg && settle_reg != 16'h0000
		|=> settle_reg == $past(settle_reg) - 16'h0001)
		else $error("settle count did not step down");
	settle_done_a: assert property (!low_power && !lp_prev_reg && settle_reg == 16'h0000
		|=> settle_reg == 16'h0000)
		else $error("settle count restarted while awake");

	saturate_c: cover property (active && fall_edge && s2_reg.level >= s2_reg.top);
	sleep_wake_c: cover property (low_power ##1 !low_power);
	stream_c: cover property (result_update ##[1:20] result_update);
	// a halted conversion clock: no edges for a stretch of system clocks
	halt_c: cover property ((!fall_edge && !rise_edge)[*8]);
	// a rising edge that arrives while asleep and must be ignored
	sleep_edge_c: cover property (low_power && rise_edge);

endmodule

// File: test/host_capture.sv
// host capture model: latches the result bus on each update pulse
// assumes result_update marks a fresh word and settling data is ignored
`timescale 1ns/1ps

module host_capture (
	// system
	input  wire logic       clock,
	input  wire logic       srst,
	// result bus and conversion clock pin
	input  wire logic [7:0] result_out,
	input  wire logic       result_update,
	input  wire logic       output_settling,
	input  wire logic       conversion_clock,
	// capture state
	output logic      [7:0] captured_word,
	output int              capture_count,
	output int              edge_faults
);
	always @(posedge clock) begin
		if (srst) begin
			captured_word <= 8'h00;
			capture_count <= 0;
			edge_faults   <= 0;
		end else if (result_update && !output_settling) begin
			captured_word <= result_out;
			capture_count <= capture_count + 1;
			// a fresh word trails a rising edge, so the pin is still high here
			if (conversion_clock !== 1'b1) edge_faults <= edge_faults + 1;
		end
	end
endmodule

// File: test/pipelined_adc_output_port_tb.sv
// testbench for the converter output port with a slow conversion clock
// assumes 16 system clocks per conversion cycle, well above the sync limit
`timescale 1ns/1ps

module pipelined_adc_output_port_tb;
	logic                  clock             = 1'b0;
	logic                  srst              = 1'b1;
	logic                  conversion_clock  = 1'b1;
	logic                  low_power_request = 1'b0;
	adc_port_pkg::sample_s sample_in         = '0;
	logic [7:0]            result_out;
	logic                  result_update;
	logic                  output_settling;
	logic [7:0]            captured_word;
	int                    capture_count;
	int                    edge_faults;
	int                    num_errors        = 0;
	int                    samples_checked   = 0;

	always #12.5 clock = ~clock;

	pipelined_adc_output_port DUT (.clock(clock), .srst(srst),
		.conversion_clock(conversion_clock), .low_power_request(low_power_request),
		.sample_in(sample_in), .result_out(result_out), .result_update(result_update),
		.output_settling(output_settling));

	host_capture host (.clock(clock), .srst(srst), .result_out(result_out),
		.result_update(result_update), .output_settling(output_settling),
		.conversion_clock(conversion_clock), .captured_word(captured_word),
		.capture_count(capture_count), .edge_faults(edge_faults));

	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// each cycle is a low phase then a high phase; ends with outputs settled
	task automatic conv_cycles(input int n);
		repeat (n) begin
			@(posedge clock) conversion_clock <= 1'b0;
			repeat (7) @(posedge clock);
			@(posedge clock) conversion_clock <= 1'b1;
			repeat (7) @(posedge clock);
		end
		#1;
	endtask

	task automatic wait_settled();
		int i;
		for (i = 0; i < 400 && output_settling !== 1'b0; i++) @(posedge clock);
		if (i == 400) begin
			num_errors++;
			$display("[FAIL] %0t settling never ended", $time);
			report_and_stop();
		end
	endtask

	// new level set in a high phase; old word must stand until the third rise
	task automatic code_case(input logic [9:0] lv, bt, tp, input logic [7:0] old, exp);
		int c0;
		@(posedge clock) sample_in <= '{level: lv, bottom: bt, top: tp};
		repeat (4) @(posedge clock);
		conv_cycles(2);
		check(result_out, old);
		conv_cycles(1);
		check(result_out, exp);
		c0 = capture_count;
		conv_cycles(2);
		check(8'(capture_count - c0), 8'h02);
		check(captured_word, exp);
	endtask

	task automatic power_case();
		int c0;
		@(posedge clock) low_power_request <= 1'b1;
		sample_in <= '{level: 10'h0c0, bottom: 10'h000, top: 10'h100};
		repeat (4) @(posedge clock);
		c0 = capture_count;
		conv_cycles(4);
		check(result_out, 8'h40);
		check(8'(capture_count - c0), 8'h00);
		@(posedge clock) low_power_request <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
		check(8'(output_settling), 8'h01);
		wait_settled();
		conv_cycles(3);
		check(result_out, 8'hc0);
	endtask

	task automatic halt_case();
		int c0;
		c0 = capture_count;
		repeat (64) @(posedge clock);
		#1;
		check(result_out, 8'hc0);
		check(8'(capture_count - c0), 8'h00);
		conv_cycles(3);
		check(8'(capture_count - c0), 8'h03);
	endtask

	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		#1;
		check(8'(output_settling), 8'h01);
		wait_settled();
		code_case(10'h080, 10'h000, 10'h100, 8'h00, 8'h80);
		code_case(10'h010, 10'h020, 10'h100, 8'h80, 8'h00);
		code_case(10'h12c, 10'h000, 10'h100, 8'h00, 8'hff);
		code_case(10'h040, 10'h000, 10'h100, 8'hff, 8'h40);
		power_case();
		halt_case();
		check(8'(edge_faults), 8'h00);
		report_and_stop();
	end
endmodule
